// ---- pkg/tmgw_consts.svh ----
// Purpose: Register offsets, field positions and reset values of the timer gate/wave block
// Assumes: Byte addresses on an 8-bit APB address, one 32-bit word per register
// Notes: Definitions only; included by the package and the top module
`ifndef TMGW_CONSTS_SVH
`define TMGW_CONSTS_SVH

// Global register byte offsets (group 0)
`define TMGW_OFS_BTCTRL 8'h00
`define TMGW_OFS_BTCNT 8'h04
`define TMGW_OFS_PERIOD 8'h08
`define TMGW_OFS_CHEN 8'h0C
`define TMGW_OFS_FSEL 8'h10
`define TMGW_OFS_ODIS 8'h14
`define TMGW_OFS_MLVL 8'h18
`define TMGW_OFS_PIO 8'h1C

// Per-channel register groups, selected by paddr[7:5], channel by paddr[4:2]
`define TMGW_GRP_WCTL 3'h2
`define TMGW_GRP_CMP 3'h3
`define TMGW_GRP_CCTL 3'h4
`define TMGW_GRP_CRES 3'h5

// base_timer_ctrl fields
`define TMGW_BT_RUN 0
`define TMGW_BT_DIR_LSB 2
`define TMGW_BT_RST0 4
`define TMGW_BT_RESET_SEL_TWO 5
`define TMGW_BT_RESET_ON_PERIOD_MATCH 6
`define TMGW_BT_DIV_LSB 8

// wave_ctrl fields
`define TMGW_WC_MODE_LSB 0
`define TMGW_WC_DFLT 2
`define TMGW_WC_INV 3
`define TMGW_WC_RLD 4

// capture_ctrl fields
`define TMGW_CC_EDGE_LSB 0
`define TMGW_CC_GATE 2
`define TMGW_CC_GOC 3
`define TMGW_CC_REOPEN 4
`define TMGW_CC_CLOSED 8

// Reset values
`define TMGW_RST_DIV 8'h00
`define TMGW_RST_WORD16 16'h0000
`define TMGW_RST_BYTE 8'h00

`endif

// ---- pkg/tmgw_pkg.sv ----
// Purpose: Types shared by the timer gate/wave block
// Assumes: Constants come from tmgw_consts.svh
// Notes: Mode codes follow the two-bit mode-select field
package tmgw_pkg;
    `include "tmgw_consts.svh"

    // Waveform mode field; only single-phase is generated here
    typedef enum logic [1:0] {
        TMGW_MODE_SINGLE = 2'h0,
        TMGW_MODE_SETRST = 2'h1,
        TMGW_MODE_INVERT = 2'h2
    } tmgw_mode_e;

    // Compare-match output level select, two bits per channel
    typedef enum logic [1:0] {
        TMGW_ML_NORMAL = 2'h0,
        TMGW_ML_LOW = 2'h1,
        TMGW_ML_HIGH = 2'h2,
        TMGW_ML_HIGH2 = 2'h3
    } tmgw_mlvl_e;
endpackage : tmgw_pkg

// ---- src/tmgw_sync.sv ----
// Purpose: Three-flop synchroniser with agreement filter and edge pulses for trigger pins
// Assumes: Pins are asynchronous to pclk
// Notes: A level change is accepted once stages two and three agree
`timescale 1ns/1ps
module tmgw_sync import tmgw_pkg::*; #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pins in, filtered events out
    input wire logic [W-1:0] pin,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
    } tmgw_sync_s;

    tmgw_sync_s q;
    tmgw_sync_s d;

    // First stage feeds only the second; filter looks at stages two and three
    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.stable = (q.s2 == q.s3) ? q.s3 : q.stable;
        d.rise = ~(q.s2 ^ q.s3) & q.s3 & ~q.stable;
        d.fall = ~(q.s2 ^ q.s3) & ~q.s3 & q.stable;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise = q.rise;
    assign fall = q.fall;
endmodule : tmgw_sync

// ---- src/tmgw_top.sv ----
// Purpose: Base timer, single-phase waveform channels and gated time capture behind APB
// Assumes: pclk 250 MHz; base_count_clock is a divided enable of pclk
// Notes: Inverted and set/reset modes only hold their pin; capture has only the synchroniser's agreement filter and no prescaler
`timescale 1ns/1ps
`include "tmgw_consts.svh"
// Contract
// - Gated channels 6 and 7 ignore triggers after the first capture.
// - Writing 1 to the gate reopen command accepts triggers again.
// - Reopen-on-match reopens gate when base timer equals compare of channel j-2.
// - Three waveform modes exist; mode 00b selects single-phase output.
// - Single-phase, not inverted: pin goes high on compare match.
// - Single-phase: pin goes low when base timer reaches zero.
// - Base timer clears on channel-0 or period match per reset select.
// - Reset operation: period n+2 counts, opposite level n+2-m counts.
// - Channel enable 1 starts the waveform, 0 stops it.
// - Each compare match in single-phase mode raises the channel request.
// - Default-level bit sets start level; invert bit inverts the pin.
// - Compare-match output holds a fixed level; resumes at next match after release.
// - Output disable hands the pin to programmable I/O until cleared.
// - Reload bit picks when a new compare value becomes active.
// - With channel-0 reset, channel 0 is the period; only 1 to 7 output.
// - Capture copies the base timer on the selected trigger edge.
module tmgw_top import tmgw_pkg::*; #(
    parameter int NCH = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel pins and requests
    input wire logic [NCH-1:0] trigger_in_pin,
    output logic [NCH-1:0] wave_out_pin,
    output logic [NCH-1:0] chan_irq
);
    typedef struct packed {
        logic [15:0] bt;
        logic [7:0] pre;
        logic [7:0] div;
        logic [1:0] count_dir;
        logic reset_on_ch0_match;
        logic reset_sel_two;
        logic reset_on_period_match;
        logic run;
        logic [15:0] period_reg;
        logic [NCH-1:0] chan_enable;
        logic [NCH-1:0] func_select;
        logic [NCH-1:0] out_disable;
        logic [NCH-1:0] pio;
        logic [NCH-1:0][1:0] match_level;
        logic [NCH-1:0][4:0] wave_ctrl;
        logic [NCH-1:0][3:0] capture_ctrl;
        logic [NCH-1:0][15:0] cmp_buf;
        logic [NCH-1:0][15:0] chan_compare;
        logic [NCH-1:0][15:0] capture_result;
        logic [NCH-1:0] gclosed;
        logic [NCH-1:0] lvl;
        logic [NCH-1:0] hold;
        logic [NCH-1:0] fix;
        logic [NCH-1:0] on_d;
        logic [NCH-1:0] out;
        logic [NCH-1:0] irq;
        logic [31:0] rdata;
        logic slverr;
    } tmgw_top_s;

    tmgw_top_s q;
    tmgw_top_s d;
    logic [NCH-1:0] trig_rise;
    logic [NCH-1:0] trig_fall;
    logic tick;
    logic rmatch;
    logic zero;
    logic [NCH-1:0] match_ev;
    logic [NCH-1:0] cap_ev;
    logic [NCH-1:0] wave_on;
    logic [NCH-1:0] reopen_wr;

    // Trigger pins cross into pclk here
    tmgw_sync #(.W(NCH)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(trigger_in_pin),
        .rise(trig_rise),
        .fall(trig_fall)
    );

    // Next-state logic: counter, bus, then per-channel so capture sets win over clears
    always_comb begin
        logic [2:0] grp;
        logic [2:0] ch;
        logic wr;
        logic [15:0] gcmp;
        grp = paddr[7:5];
        ch = paddr[4:2];
        wr = psel & penable & pwrite & ~q.slverr;
        gcmp = '0;
        d = q;
        d.irq = '0;
        match_ev = '0;
        cap_ev = '0;
        wave_on = '0;
        reopen_wr = '0;
        // Count enable from the divider; counter only moves on it
        tick = q.run && (q.pre == q.div);
        d.pre = (tick || !q.run) ? 8'h00 : q.pre + 8'h01;
        // Clear one count after the reset compare, which yields an n+2 period
        rmatch = tick && ((q.reset_on_ch0_match && !q.reset_sel_two && !q.reset_on_period_match &&
                 q.bt == q.chan_compare[0] + 16'h0001) ||
                 (q.reset_on_period_match && !q.reset_sel_two && !q.reset_on_ch0_match &&
                 q.bt == q.period_reg + 16'h0001));
        zero = tick && (q.bt == 16'h0000);
        if (tick) begin
            d.bt = rmatch ? 16'h0000 : q.bt + 16'h0001;
        end
        // Setup phase: decode and latch read data so prdata comes from a flop
        if (psel && !penable) begin
            d.rdata = '0;
            d.slverr = 1'b0;
            if (paddr[1:0] != 2'h0) begin
                d.slverr = 1'b1;
            end else if (paddr == `TMGW_OFS_BTCTRL) begin
                d.rdata[`TMGW_BT_RUN] = q.run;
                d.rdata[`TMGW_BT_DIR_LSB +: 2] = q.count_dir;
                d.rdata[`TMGW_BT_RST0] = q.reset_on_ch0_match;
                d.rdata[`TMGW_BT_RESET_SEL_TWO] = q.reset_sel_two;
                d.rdata[`TMGW_BT_RESET_ON_PERIOD_MATCH] = q.reset_on_period_match;
                d.rdata[`TMGW_BT_DIV_LSB +: 8] = q.div;
            end else if (paddr == `TMGW_OFS_BTCNT) begin
                d.rdata[15:0] = q.bt;
            end else if (paddr == `TMGW_OFS_PERIOD) begin
                d.rdata[15:0] = q.period_reg;
            end else if (paddr == `TMGW_OFS_CHEN) begin
                d.rdata[NCH-1:0] = q.chan_enable;
            end else if (paddr == `TMGW_OFS_FSEL) begin
                d.rdata[NCH-1:0] = q.func_select;
            end else if (paddr == `TMGW_OFS_ODIS) begin
                d.rdata[NCH-1:0] = q.out_disable;
            end else if (paddr == `TMGW_OFS_MLVL) begin
                d.rdata[2*NCH-1:0] = q.match_level;
            end else if (paddr == `TMGW_OFS_PIO) begin
                d.rdata[NCH-1:0] = q.pio;
                d.rdata[8 +: NCH] = q.out;
            end else if (32'(ch) >= NCH) begin
                d.slverr = 1'b1;
            end else if (grp == `TMGW_GRP_WCTL) begin
                d.rdata[4:0] = q.wave_ctrl[ch];
            end else if (grp == `TMGW_GRP_CMP) begin
                d.rdata[15:0] = q.chan_compare[ch];
            end else if (grp == `TMGW_GRP_CCTL) begin
                d.rdata[3:0] = q.capture_ctrl[ch];
                d.rdata[`TMGW_CC_CLOSED] = q.gclosed[ch];
            end else if (grp == `TMGW_GRP_CRES) begin
                d.rdata[15:0] = q.capture_result[ch];
            end else begin
                d.slverr = 1'b1;
            end
        end
        // Access phase: writes take effect on the single pready edge
        if (wr) begin
            if (paddr == `TMGW_OFS_BTCTRL) begin
                d.run = pwdata[`TMGW_BT_RUN];
                d.count_dir = pwdata[`TMGW_BT_DIR_LSB +: 2];
                d.reset_on_ch0_match = pwdata[`TMGW_BT_RST0];
                d.reset_sel_two = pwdata[`TMGW_BT_RESET_SEL_TWO];
                d.reset_on_period_match = pwdata[`TMGW_BT_RESET_ON_PERIOD_MATCH];
                d.div = pwdata[`TMGW_BT_DIV_LSB +: 8];
            end else if (paddr == `TMGW_OFS_BTCNT) begin
                d.bt = pwdata[15:0];
            end else if (paddr == `TMGW_OFS_PERIOD) begin
                d.period_reg = pwdata[15:0];
            end else if (paddr == `TMGW_OFS_CHEN) begin
                d.chan_enable = pwdata[NCH-1:0];
            end else if (paddr == `TMGW_OFS_FSEL) begin
                d.func_select = pwdata[NCH-1:0];
            end else if (paddr == `TMGW_OFS_ODIS) begin
                d.out_disable = pwdata[NCH-1:0];
            end else if (paddr == `TMGW_OFS_MLVL) begin
                d.match_level = pwdata[2*NCH-1:0];
            end else if (paddr == `TMGW_OFS_PIO) begin
                d.pio = pwdata[NCH-1:0];
            end else if (grp == `TMGW_GRP_WCTL) begin
                d.wave_ctrl[ch] = pwdata[4:0];
            end else if (grp == `TMGW_GRP_CMP) begin
                d.cmp_buf[ch] = pwdata[15:0];
                if (!q.wave_ctrl[ch][`TMGW_WC_RLD]) begin
                    d.chan_compare[ch] = pwdata[15:0];
                end
            end else if (grp == `TMGW_GRP_CCTL) begin
                d.capture_ctrl[ch] = pwdata[3:0];
                reopen_wr[ch] = pwdata[`TMGW_CC_REOPEN];
            end
        end
        // Per-channel waveform and capture
        for (int i = 0; i < NCH; i++) begin
            match_ev[i] = tick && (q.bt == q.chan_compare[i]);
            wave_on[i] = q.chan_enable[i] && !q.func_select[i] &&
                         q.wave_ctrl[i][1:0] == TMGW_MODE_SINGLE &&
                         !(i == 0 && q.reset_on_ch0_match);
            d.on_d[i] = wave_on[i];
            if (!wave_on[i] || !q.on_d[i]) begin
                d.lvl[i] = q.wave_ctrl[i][`TMGW_WC_DFLT];
                d.hold[i] = 1'b0;
            end else begin
                if (zero) begin
                    d.lvl[i] = q.wave_ctrl[i][`TMGW_WC_DFLT];
                end
                if (match_ev[i]) begin
                    d.irq[i] = 1'b1;
                    if (q.match_level[i] != TMGW_ML_NORMAL) begin
                        d.hold[i] = 1'b1;
                        d.fix[i] = (q.match_level[i] != TMGW_ML_LOW);
                    end else begin
                        d.hold[i] = 1'b0;
                        d.lvl[i] = ~q.wave_ctrl[i][`TMGW_WC_DFLT];
                    end
                end
            end
            // Buffered compare moves in when the timer passes zero
            if (q.wave_ctrl[i][`TMGW_WC_RLD] && zero) begin
                d.chan_compare[i] = q.cmp_buf[i];
            end
            // Disabled pin carries the software I/O value
            d.out[i] = q.out_disable[i] ? q.pio[i] :
                       q.hold[i] ? q.fix[i] : (q.lvl[i] ^ q.wave_ctrl[i][`TMGW_WC_INV]);
            // Gate reopen clears first; a capture in the same cycle closes it again
            if (i >= NCH - 2) begin
                gcmp = q.chan_compare[(i + NCH - 2) % NCH];
                if (reopen_wr[i] || (q.capture_ctrl[i][`TMGW_CC_GOC] && tick && q.bt == gcmp)) begin
                    d.gclosed[i] = 1'b0;
                end
            end
            cap_ev[i] = q.chan_enable[i] && q.func_select[i] && !q.gclosed[i] &&
                        ((q.capture_ctrl[i][0] && trig_rise[i]) || (q.capture_ctrl[i][1] && trig_fall[i]));
            if (cap_ev[i]) begin
                d.capture_result[i] = q.bt;
                d.irq[i] = 1'b1;
                if (i >= NCH - 2 && q.capture_ctrl[i][`TMGW_CC_GATE]) begin
                    d.gclosed[i] = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Zero-wait slave: read data was prepared in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & q.slverr;
    assign prdata = q.rdata;
    assign wave_out_pin = q.out;
    assign chan_irq = q.irq;

    AST_GATE_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        q.gclosed[NCH-1] |=> $stable(q.capture_result[NCH-1]))
        else $error("capture taken while gate closed");
    AST_GATE_CMD: assert property (@(posedge pclk) disable iff (!presetn)
        reopen_wr[NCH-2] && !cap_ev[NCH-2] |=> !q.gclosed[NCH-2])
        else $error("gate not reopened by command");
    AST_GATE_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        q.capture_ctrl[NCH-1][`TMGW_CC_GOC] && tick && q.bt == q.chan_compare[NCH-3] && !cap_ev[NCH-1]
        |=> !q.gclosed[NCH-1])
        else $error("gate not reopened on compare match");
    AST_HIGH_ON_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        match_ev[1] && wave_on[1] && q.on_d[1] && q.match_level[1] == TMGW_ML_NORMAL &&
        !q.wave_ctrl[1][`TMGW_WC_DFLT] && !q.wave_ctrl[1][`TMGW_WC_INV] && !q.out_disable[1]
        ##1 (wave_on[1] && !q.out_disable[1] && !q.wave_ctrl[1][`TMGW_WC_INV]) |=> wave_out_pin[1])
        else $error("pin not high after compare match");
    AST_LOW_ON_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        zero && wave_on[1] && !match_ev[1] && !q.wave_ctrl[1][`TMGW_WC_DFLT] |=> !q.lvl[1])
        else $error("level not low at timer zero");
    AST_BT_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        rmatch && !(psel && penable && pwrite) |=> q.bt == 16'h0000)
        else $error("base timer not cleared on reset match");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        match_ev[1] && wave_on[1] && q.on_d[1] |=> chan_irq[1])
        else $error("no request on compare match");
    AST_START_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        wave_on[2] && !q.on_d[2] |=> q.lvl[2] == $past(q.wave_ctrl[2][`TMGW_WC_DFLT]))
        else $error("waveform did not start at default level");
    AST_ODIS: assert property (@(posedge pclk) disable iff (!presetn)
        q.out_disable[NCH-2] |=> wave_out_pin[NCH-2] == $past(q.pio[NCH-2]))
        else $error("disabled pin does not follow I/O value");
    AST_CH0_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        q.reset_on_ch0_match ##1 (!q.out_disable[0] && $stable(q.wave_ctrl[0]))
        |=> wave_out_pin[0] == $past(q.wave_ctrl[0][`TMGW_WC_DFLT] ^ q.wave_ctrl[0][`TMGW_WC_INV]))
        else $error("channel 0 waveform active while it sets the period");
endmodule : tmgw_top

// ---- sim/tmgw_pin_meter.sv ----
// Purpose: Stand-in for the circuitry fed by the waveform pins
// Assumes: Pins change only just after pclk rising edges
// Notes: Reports the last finished high and low run per pin, in pclk cycles, and an edge count
`timescale 1ns/1ps
module tmgw_pin_meter #(
    parameter int NCH = 8
) (
    // Clock
    input wire logic pclk,
    // Watched pins
    input wire logic [NCH-1:0] pin,
    // Measurements
    output logic [16:0] hi_len [NCH],
    output logic [16:0] lo_len [NCH],
    output int edges [NCH]
);
    logic [16:0] run [NCH];
    logic [NCH-1:0] last;

    // Start from the reset level of the pins so the first run is counted whole
    initial begin
        last = '0;
        for (int i = 0; i < NCH; i++) begin
            run[i] = 17'h00000;
            edges[i] = 0;
            hi_len[i] = 17'h00000;
            lo_len[i] = 17'h00000;
        end
    end

    // A run is only published once it has ended, so partial runs never leak out
    always @(posedge pclk) begin
        for (int i = 0; i < NCH; i++) begin
            if (pin[i] !== last[i]) begin
                if (last[i] === 1'b1) begin
                    hi_len[i] <= run[i];
                end else begin
                    lo_len[i] <= run[i];
                end
                edges[i] <= edges[i] + 1;
                run[i] <= 17'h00001;
            end else begin
                run[i] <= run[i] + 17'h00001;
            end
        end
        last <= pin;
    end
endmodule : tmgw_pin_meter

// ---- sim/timer_gate_and_single_phase_wave_bench.sv ----
// Purpose: Self-checking bench for the timer gate and single-phase wave block
// Assumes: Count enable every pclk (divider 0), so counts equal cycles
// Notes: Random period and compare values from a fixed xorshift seed
`timescale 1ns/1ps
`include "tmgw_consts.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD %0t got %0h exp %0h", $time, (got), (exp)); end end
module timer_gate_and_single_phase_wave_bench;
    import tmgw_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, c1, seed;
    logic e;
    logic [7:0] trigger_in_pin, wave_out_pin, chan_irq;
    logic [16:0] hi_len [8];
    logic [16:0] lo_len [8];
    int edges [8];
    int irqs [8];
    int ir [8];
    int num_errors, num_checks, P;
    logic [15:0] n;
    logic [15:0] m [8];

    tmgw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger_in_pin(trigger_in_pin), .wave_out_pin(wave_out_pin), .chan_irq(chan_irq));
    tmgw_pin_meter meter (.pclk(pclk), .pin(wave_out_pin), .hi_len(hi_len), .lo_len(lo_len), .edges(edges));

    // Clock and interrupt pulse tally
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        for (int i = 0; i < 8; i++) begin
            if (chan_irq[i] === 1'b1) irqs[i]++;
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [7:0] ca(input logic [2:0] g, input int c);
        return {g, 3'(c), 2'b00};
    endfunction : ca
    // Low run is m counts, high run the rest of the period
    function automatic logic [16:0] exp_len(input logic hi, input int c);
        return hi ? 17'(P) - 17'(m[c]) : 17'(m[c]);
    endfunction : exp_len

    task automatic wt(input int k);
        repeat (k) @(posedge pclk);
    endtask : wt
    // APB: a fresh edge first, so no signal is assigned twice in one time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wreg
    task automatic rreg(input logic [7:0] a);
        apb(1'b0, a, 32'h00000000);
    endtask : rreg
    // Timer is stopped and cleared before a new period, else a shorter period would wrap through 65536
    task automatic setup(input logic [31:0] btc);
        wreg(`TMGW_OFS_BTCTRL, 32'h00000000);
        wreg(`TMGW_OFS_BTCNT, 32'h00000000);
        wreg(`TMGW_OFS_FSEL, 32'h00000000);
        wreg(`TMGW_OFS_PERIOD, 32'(n));
        for (int c = 0; c < 8; c++) begin
            wreg(ca(`TMGW_GRP_WCTL, c), 32'h00000000);
            wreg(ca(`TMGW_GRP_CMP, c), (c == 0 && btc[4]) ? 32'(n) : 32'(m[c]));
        end
        wreg(`TMGW_OFS_CHEN, 32'h000000FF);
        wreg(`TMGW_OFS_BTCTRL, btc);
    endtask : setup
    task automatic chk_wave(input int c, input logic out_invert);
        `CHK(out_invert ? hi_len[c] : lo_len[c], exp_len(1'b0, c))
        `CHK(out_invert ? lo_len[c] : hi_len[c], exp_len(1'b1, c))
    endtask : chk_wave
    task automatic quiet(input int c, input logic lvl);
        int k;
        k = edges[c];
        wt(2 * P);
        `CHK(edges[c] - k, 0)
        `CHK(wave_out_pin[c], lvl)
    endtask : quiet
    task automatic pulse(input int c);
        trigger_in_pin[c] <= 1'b1;
        wt(8);
        trigger_in_pin[c] <= 1'b0;
        wt(8);
    endtask : pulse
    task automatic summarize();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // Watchdog sized for the 65536-count free-running period plus the rest
    initial begin
        wt(95000);
        num_errors++;
        $display("BAD %0t timeout", $time);
        summarize();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, trigger_in_pin} = '0;
        seed = 32'h99F73C81;
        num_errors = 0;
        num_checks = 0;
        wt(12);
        presetn <= 1'b1;
        // Reset values and refused addresses
        rreg(`TMGW_OFS_BTCTRL);
        `CHK(r, 32'h00000000)
        rreg(8'h24);
        `CHK({e, r}, 33'h100000000)
        rreg(8'h02);
        `CHK(e, 1'b1)
        // Random periods and compares; last pass clears on channel 0 match
        for (int it = 0; it < 3; it++) begin
            n = 16'h0008 + 16'(rnd() % 32'd40);
            P = 32'(n) + 2;
            for (int c = 0; c < 8; c++) m[c] = 16'h0001 + 16'(rnd() % (32'(n) - 1));
            m[1] = n - 16'h0001;
            m[2] = 16'h0001;
            setup(it == 2 ? 32'h00000011 : 32'h00000041);
            wt(3 * P + 8);
            for (int c = (it == 2) ? 1 : 0; c < 8; c++) chk_wave(c, 1'b0);
            if (it == 2) quiet(0, 1'b0);
            for (int c = 0; c < 8; c++) ir[c] = irqs[c];
            wt(2 * P);
            for (int c = (it == 2) ? 1 : 0; c < 8; c++) `CHK(irqs[c] - ir[c], 2)
        end
        setup(32'h00000041);
        wt(3 * P);
        // Non-single modes hold the pin
        for (int md = 1; md < 3; md++) begin
            wreg(ca(`TMGW_GRP_WCTL, 4), 32'(md));
            wt(4);
            quiet(4, 1'b0);
        end
        wreg(ca(`TMGW_GRP_WCTL, 4), 32'h00000000);
        wt(2 * P);
        ir[4] = edges[4];
        wt(2 * P);
        `CHK(edges[4] - ir[4], 4)
        // Inversion, default level, stop and restart
        wreg(ca(`TMGW_GRP_WCTL, 2), 32'h00000008);
        wt(3 * P);
        chk_wave(2, 1'b1);
        wreg(ca(`TMGW_GRP_WCTL, 3), 32'h00000004);
        wreg(`TMGW_OFS_CHEN, 32'h000000F7);
        wt(4);
        quiet(3, 1'b1);
        wreg(`TMGW_OFS_CHEN, 32'h000000FF);
        wt(3 * P);
        chk_wave(3, 1'b1);
        // Compare-match output fixed low, fixed high, then released
        wreg(`TMGW_OFS_MLVL, 32'h00000400);
        wt(P + 4);
        quiet(5, 1'b0);
        wreg(`TMGW_OFS_MLVL, 32'h00000800);
        wt(P + 4);
        quiet(5, 1'b1);
        wreg(`TMGW_OFS_MLVL, 32'h00000000);
        wt(3 * P);
        chk_wave(5, 1'b0);
        // Output disable hands the pin to the I/O value
        wreg(`TMGW_OFS_PIO, 32'h00000040);
        wreg(`TMGW_OFS_ODIS, 32'h00000040);
        wt(3);
        quiet(6, 1'b1);
        wreg(`TMGW_OFS_PIO, 32'h00000000);
        wt(3);
        `CHK(wave_out_pin[6], 1'b0)
        wreg(`TMGW_OFS_ODIS, 32'h00000000);
        wt(3 * P);
        chk_wave(6, 1'b0);
        // Buffered compare waits for the timer to pass zero
        wreg(ca(`TMGW_GRP_WCTL, 1), 32'h00000010);
        wreg(`TMGW_OFS_BTCTRL, 32'h00000040);
        wreg(ca(`TMGW_GRP_CMP, 1), 32'h00000001);
        rreg(ca(`TMGW_GRP_CMP, 1));
        `CHK(r, 32'(m[1]))
        wreg(`TMGW_OFS_BTCTRL, 32'h00000041);
        wt(P + 4);
        rreg(ca(`TMGW_GRP_CMP, 1));
        `CHK(r, 32'h00000001)
        // Gate on channel 6, falling-edge trigger: one capture, then closed until reopened
        wreg(`TMGW_OFS_FSEL, 32'h000000C0);
        wreg(ca(`TMGW_GRP_CCTL, 6), 32'h00000006);
        ir[6] = irqs[6];
        pulse(6);
        rreg(ca(`TMGW_GRP_CCTL, 6));
        `CHK(r[8], 1'b1)
        rreg(ca(`TMGW_GRP_CRES, 6));
        c1 = r;
        `CHK(r < 32'(P), 1'b1)
        pulse(6);
        wt(P);
        rreg(ca(`TMGW_GRP_CRES, 6));
        `CHK(r, c1)
        `CHK(irqs[6] - ir[6], 1)
        wreg(ca(`TMGW_GRP_CCTL, 6), 32'h00000016);
        rreg(ca(`TMGW_GRP_CCTL, 6));
        `CHK(r[8], 1'b0)
        pulse(6);
        `CHK(irqs[6] - ir[6], 2)
        // Channel 7 reopens on match with channel 5; timer held so it cannot reopen early
        wreg(`TMGW_OFS_BTCTRL, 32'h00000040);
        wreg(ca(`TMGW_GRP_CCTL, 7), 32'h0000000D);
        pulse(7);
        rreg(ca(`TMGW_GRP_CCTL, 7));
        `CHK(r[8], 1'b1)
        wreg(`TMGW_OFS_BTCTRL, 32'h00000041);
        wt(P + 4);
        rreg(ca(`TMGW_GRP_CCTL, 7));
        `CHK(r[8], 1'b0)
        // Free running: 65536-count period, high run of 65536 minus the compare per channel
        setup(32'h00000001);
        wt(65536 + 64);
        for (int c = 0; c < 8; c++) `CHK(hi_len[c], 17'h10000 - 17'(m[c]))
        summarize();
    end
endmodule : timer_gate_and_single_phase_wave_bench
